// ==== rtl/xap_unit.sv ====
// External data address pointer unit: two data pointers with top bytes,
// pointer select control, and register-indirect high/top address sources.
// Assumes one AHB-Lite master and CPU strobes synchronous to hclk.
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps

// Functional notes
// - Indirect move, source select 0: address bits 15..8 from port two latch.
// - Indirect move, source select 1: high byte from indirect high address.
// - Indirect move: address bits 23..16 from indirect top address.
// - Indirect top address never affects pointer-based moves.
// - Pointer move: low 16 bits from selected pointer high and low.
// - Pointer move: bits 23..16 from selected pointer top byte.
// - Address path is 24 bits, up to 16 megabytes.
// - Select bit 1 picks pointer one, 0 picks pointer zero.
// - Step code 00 inc both, 11 dec both, 01 dec zero inc one.
// - Auto-toggle flips select after each pointer-using instruction.
// - Hardware may change select; reads return selection in effect.
// - Wide mode: pointer steps carry into and borrow from top byte.
// - Compatible mode: steps leave top bytes alone; both pointers alike.
// - Memory below 64 kilobytes: top bytes do not affect address.
// - All these registers reset to zero and are read/write.
// - Mode field 00 compatible, upper bit 1 wide.
// - Source select bit lives in the addressing mode control register.
module xap_unit
    import xap_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,

    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,

    // CPU move requests
    input wire logic cpu_ptr_move,
    input wire logic cpu_ind_move,
    input wire logic [7:0] cpu_work_reg,
    input wire logic [7:0] port_two_latch,
    input wire logic cpu_ptr_step,

    // XRAM address port
    output logic [xap_pkg::XRAM_ADDR_W-1:0] xram_addr,
    output logic xram_addr_valid
);
    import xap_pkg::*;

    // Pointers, top byte above high above low
    logic [23:0] ptr0_ff;
    logic [23:0] ptr1_ff;
    logic [23:0] nxt_ptr0;
    logic [23:0] nxt_ptr1;

    // Control and indirect address registers
    logic [7:0] psc_ff;
    logic [7:0] amc_ff;
    logic [7:0] ind_high_ff;
    logic [7:0] ind_top_ff;

    // Bus data phase state
    logic wr_pend_ff;
    logic [7:0] wr_idx_ff;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;

    // Address port registers
    logic [23:0] addr_ff;
    logic valid_ff;

    // Bus decode
    logic addr_ok;
    logic acc_take;
    logic rd_take;
    logic wr_take;
    logic [7:0] acc_idx;
    logic [7:0] rd_byte;
    logic [7:0] wr_byte;

    // Per-register write strobes, live in the data phase
    logic wr_p0_low;
    logic wr_p0_high;
    logic wr_p0_top;
    logic wr_p1_low;
    logic wr_p1_high;
    logic wr_p1_top;
    logic wr_psc;
    logic wr_amc;
    logic wr_ind_high;
    logic wr_ind_top;

    // Decoded control fields
    logic sel;
    logic wide;
    logic auto_tog;
    logic dec0;
    logic dec1;
    logic high_src;

    // Pointer use and step enables
    logic ptr_used;
    logic step0;
    logic step1;

    // Candidate move addresses
    logic [23:0] ptr_sel_val;
    logic [23:0] ind_addr;

    // Plus or minus one; compat mode wraps inside 16 bits
    function automatic logic [23:0] step_ptr(input logic [23:0] v, input logic dec, input logic wd);
        logic [23:0] r;
        if (dec) begin
            r = v - 24'h00_0001;
        end else begin
            r = v + 24'h00_0001;
        end
        if (!wd) begin
            r = {v[23:16], r[15:0]};
        end
        return r;
    endfunction : step_ptr

    // Write strobe decode, shared by every register
    function automatic logic wr_hit(input logic pend, input logic [7:0] held, input logic [7:0] idx);
        return pend && (held == idx);
    endfunction : wr_hit

    // Small memories ignore the top byte entirely
    function automatic logic [23:0] fold_addr(input logic [23:0] a);
        logic [23:0] r;
        r = a;
        if (XRAM_BYTES < XRAM_64K) begin
            r[23:16] = 8'h00;
        end
        return r;
    endfunction : fold_addr

    // Read value of a register index, zero when unmapped
    function automatic logic [7:0] reg_value(
        input logic [7:0] idx,
        input logic [23:0] p0,
        input logic [23:0] p1,
        input logic [7:0] pc,
        input logic [7:0] am,
        input logic [7:0] ih,
        input logic [7:0] it
    );
        logic [7:0] r;
        r = 8'h00;
        unique case (idx)
            // Pointer low and high bytes
            IDX_DATA_POINTER0_LOW: r = p0[7:0];
            IDX_DATA_POINTER0_HIGH: r = p0[15:8];
            IDX_DATA_POINTER1_LOW: r = p1[7:0];
            IDX_DATA_POINTER1_HIGH: r = p1[15:8];
            // Select control, unused bits read zero
            IDX_POINTER_SELECT_CONTROL: r = pc & PSC_WR_MASK;
            // Pointer top bytes
            IDX_DATA_POINTER0_TOP: r = p0[23:16];
            IDX_DATA_POINTER1_TOP: r = p1[23:16];
            // Mode control and indirect sources
            IDX_ADDRESSING_MODE_CONTROL: r = am & AMC_WR_MASK;
            IDX_INDIRECT_HIGH_ADDRESS: r = ih;
            IDX_INDIRECT_TOP_ADDRESS: r = it;
            // Unmapped indices read zero
            default: r = 8'h00;
        endcase
        return r;
    endfunction : reg_value

    // Bus decode; upper address bits must be clear
    assign addr_ok = (haddr[31:10] == 22'h00_0000)
        && (haddr[1:0] == 2'h0);
    assign acc_take = hsel
        && hready
        && (htrans == HTRANS_NONSEQ)
        && addr_ok;
    assign acc_idx = haddr[9:2];
    assign hreadyout = 1'b1; // Zero wait state, every register is a flop
    assign hresp = HRESP_OKAY;
    assign hrdata = rdata_ff;

    // Address phase split by direction
    assign rd_take = acc_take && !hwrite;
    assign wr_take = acc_take && hwrite;

    assign sel = psc_ff[PSC_SEL_BIT];
    assign wide = amc_ff[AMC_MODE_WIDE_BIT];
    assign ptr_used = cpu_ptr_move || cpu_ptr_step;
    assign auto_tog = psc_ff[PSC_AUTO_TOGGLE_BIT];
    assign dec0 = psc_ff[PSC_STEP_LO];
    assign dec1 = psc_ff[PSC_STEP_LO+1];
    assign high_src = amc_ff[AMC_HIGH_SRC_BIT];

    // Write strobes; the index is held from the address phase
    assign wr_p0_low = wr_hit(wr_pend_ff, wr_idx_ff, IDX_DATA_POINTER0_LOW);
    assign wr_p0_high = wr_hit(wr_pend_ff, wr_idx_ff, IDX_DATA_POINTER0_HIGH);
    assign wr_p0_top = wr_hit(wr_pend_ff, wr_idx_ff, IDX_DATA_POINTER0_TOP);
    assign wr_p1_low = wr_hit(wr_pend_ff, wr_idx_ff, IDX_DATA_POINTER1_LOW);
    assign wr_p1_high = wr_hit(wr_pend_ff, wr_idx_ff, IDX_DATA_POINTER1_HIGH);
    assign wr_p1_top = wr_hit(wr_pend_ff, wr_idx_ff, IDX_DATA_POINTER1_TOP);
    assign wr_psc = wr_hit(wr_pend_ff, wr_idx_ff, IDX_POINTER_SELECT_CONTROL);
    assign wr_amc = wr_hit(wr_pend_ff, wr_idx_ff, IDX_ADDRESSING_MODE_CONTROL);
    assign wr_ind_high = wr_hit(wr_pend_ff, wr_idx_ff, IDX_INDIRECT_HIGH_ADDRESS);
    assign wr_ind_top = wr_hit(wr_pend_ff, wr_idx_ff, IDX_INDIRECT_TOP_ADDRESS);

    // Candidate move addresses, picked at the request edge
    assign ptr_sel_val = sel ? ptr1_ff : ptr0_ff;
    assign ind_addr = {
        ind_top_ff,
        high_src ? ind_high_ff : port_two_latch,
        cpu_work_reg
    };

    // Write pending flag; a write lands one edge after its address
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
        end else if (hready) begin
            wr_pend_ff <= wr_take;
        end
    end

    // Index held for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_idx_ff <= 8'h00;
        end else if (hready) begin
            wr_idx_ff <= acc_idx;
        end
    end

    // Write data byte of the data phase in flight
    assign wr_byte = hwdata[7:0];

    // Forward a write in its data phase so back-to-back read sees it
    always_comb begin
        rd_byte = reg_value(acc_idx, ptr0_ff, ptr1_ff, psc_ff, amc_ff, ind_high_ff, ind_top_ff);
        if (wr_pend_ff && (wr_idx_ff == acc_idx)) begin
            rd_byte = reg_value(acc_idx, {3{wr_byte}}, {3{wr_byte}}, wr_byte, wr_byte, wr_byte, wr_byte);
        end
    end

    // Next read data; zero outside a read data phase keeps the bus quiet
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (rd_take) begin
            nxt_rdata = {24'h00_0000, rd_byte};
        end
    end

    // Read data captured at the address phase; upper bits read zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_ff <= 32'h0000_0000;
        end else if (hready) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Step enables and stepped values; only the selected pointer moves
    assign step0 = cpu_ptr_step && !sel;
    assign step1 = cpu_ptr_step && sel;
    assign nxt_ptr0 = step_ptr(ptr0_ff, dec0, wide);
    assign nxt_ptr1 = step_ptr(ptr1_ff, dec1, wide);

    // Pointer zero: software byte write wins over a hardware step
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ptr0_ff <= {REG_RESET, REG_RESET, REG_RESET};
        end else if (wr_p0_low) begin
            ptr0_ff[7:0] <= wr_byte;
        end else if (wr_p0_high) begin
            ptr0_ff[15:8] <= wr_byte;
        end else if (wr_p0_top) begin
            ptr0_ff[23:16] <= wr_byte;
        end else if (step0) begin
            ptr0_ff <= nxt_ptr0;
        end
    end

    // Pointer one, same behaviour as pointer zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ptr1_ff <= {REG_RESET, REG_RESET, REG_RESET};
        end else if (wr_p1_low) begin
            ptr1_ff[7:0] <= wr_byte;
        end else if (wr_p1_high) begin
            ptr1_ff[15:8] <= wr_byte;
        end else if (wr_p1_top) begin
            ptr1_ff[23:16] <= wr_byte;
        end else if (step1) begin
            ptr1_ff <= nxt_ptr1;
        end
    end

    // Select control; a software write wins over the auto-toggle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            psc_ff <= REG_RESET;
        end else if (wr_psc) begin
            psc_ff <= wr_byte & PSC_WR_MASK;
        end else if (ptr_used && auto_tog) begin
            psc_ff[PSC_SEL_BIT] <= !sel;
        end
    end

    // Mode control, software only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            amc_ff <= REG_RESET;
        end else if (wr_amc) begin
            amc_ff <= wr_byte & AMC_WR_MASK;
        end
    end

    // Indirect high address source, software only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ind_high_ff <= REG_RESET;
        end else if (wr_ind_high) begin
            ind_high_ff <= wr_byte;
        end
    end

    // Indirect top address source, software only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ind_top_ff <= REG_RESET;
        end else if (wr_ind_top) begin
            ind_top_ff <= wr_byte;
        end
    end

    // Strobe for one cycle after any move request
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            valid_ff <= 1'b0;
        end else begin
            valid_ff <= cpu_ptr_move || cpu_ind_move;
        end
    end

    // Address forming; pointer move takes priority over indirect
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_ff <= 24'h00_0000;
        end else if (cpu_ptr_move) begin
            addr_ff <= ptr_sel_val;
        end else if (cpu_ind_move) begin
            addr_ff <= ind_addr;
        end
    end

    // Full 24-bit path; the top byte folds away only for small memories
    assign xram_addr = fold_addr(addr_ff);
    assign xram_addr_valid = valid_ff;
endmodule : xap_unit

// ==== rtl/xap_pkg.sv ====
// Constants for the external data address pointer unit.
// Assumes a 32-bit AHB-Lite register bus where each register takes one word.
package xap_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_DATA_POINTER0_LOW = 8'h82;
    localparam logic [7:0] IDX_DATA_POINTER0_HIGH = 8'h83;
    localparam logic [7:0] IDX_DATA_POINTER1_LOW = 8'h84;
    localparam logic [7:0] IDX_DATA_POINTER1_HIGH = 8'h85;
    localparam logic [7:0] IDX_POINTER_SELECT_CONTROL = 8'h86;
    localparam logic [7:0] IDX_DATA_POINTER0_TOP = 8'h93;
    localparam logic [7:0] IDX_DATA_POINTER1_TOP = 8'h95;
    localparam logic [7:0] IDX_ADDRESSING_MODE_CONTROL = 8'h9D;
    localparam logic [7:0] IDX_INDIRECT_HIGH_ADDRESS = 8'hDA;
    localparam logic [7:0] IDX_INDIRECT_TOP_ADDRESS = 8'hEA;
    // Register reset value
    localparam logic [7:0] REG_RESET = 8'h00;
    // Pointer select control fields
    localparam int PSC_SEL_BIT = 0;
    localparam int PSC_AUTO_TOGGLE_BIT = 5;
    localparam int PSC_STEP_LO = 6;
    localparam logic [7:0] PSC_WR_MASK = 8'hE1;
    // Addressing mode control fields
    localparam int AMC_MODE_LO = 0;
    localparam int AMC_MODE_WIDE_BIT = 1;
    localparam int AMC_HIGH_SRC_BIT = 3;
    localparam logic [7:0] AMC_WR_MASK = 8'h0B;
    // Address path
    localparam int XRAM_ADDR_W = 24;
    localparam logic [24:0] XRAM_BYTES = 25'h100_0000;
    localparam logic [24:0] XRAM_64K = 25'h001_0000;
    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;
endpackage : xap_pkg

// ==== dv/xap_unit_sva.sv ====
// Port checker for the pointer unit.
// Assumes hready is tied to hreadyout.
`timescale 1ns/1ps
module xap_unit_chk
    import xap_pkg::*;
(
    // Clock, reset and bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic hready,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // CPU side and address port
    input wire logic cpu_ptr_move,
    input wire logic cpu_ind_move,
    input wire logic [7:0] cpu_work_reg,
    input wire logic [xap_pkg::XRAM_ADDR_W-1:0] xram_addr,
    input wire logic xram_addr_valid
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Any move request, and a read address phase
    wire mv = cpu_ptr_move || cpu_ind_move;
    wire rd = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
    property p_ready; hreadyout; endproperty
    a_ready: assert property (p_ready) else $error("wait state seen");
    property p_okay; hresp == HRESP_OKAY; endproperty
    a_okay: assert property (p_okay) else $error("bad response");
    property p_valid; mv |=> xram_addr_valid; endproperty
    a_valid: assert property (p_valid) else $error("no strobe");
    property p_quiet; !mv |=> !xram_addr_valid; endproperty
    a_quiet: assert property (p_quiet) else $error("stray strobe");
    property p_low; cpu_ind_move && !cpu_ptr_move |=> xram_addr[7:0] == $past(cpu_work_reg); endproperty
    a_low: assert property (p_low) else $error("low byte wrong");
    property p_hold; !mv |=> $stable(xram_addr); endproperty
    a_hold: assert property (p_hold) else $error("address moved");
    property p_upper; hrdata[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper bits set");
    property p_idle; !rd |=> hrdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data leaks");
endmodule : xap_unit_chk
bind xap_unit xap_unit_chk u_chk(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .hready(hready), .htrans(htrans),
    .hwrite(hwrite), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cpu_ptr_move(cpu_ptr_move),
    .cpu_ind_move(cpu_ind_move), .cpu_work_reg(cpu_work_reg), .xram_addr(xram_addr),
    .xram_addr_valid(xram_addr_valid));

// ==== dv/xap_xram_model.sv ====
// Far-side data memory model: latches each address presented.
// Assumes the address counts only while its strobe is high.
`timescale 1ns/1ps
module xap_xram_model (
    // Clock and address port
    input wire logic hclk,
    input wire logic [23:0] xram_addr,
    input wire logic xram_addr_valid,
    // Last address taken
    output logic [23:0] seen_addr
);
    // Strobe gates capture so stale addresses never count
    always_ff @(posedge hclk) begin
        if (xram_addr_valid) begin
            seen_addr <= xram_addr;
        end
    end
endmodule : xap_xram_model

// ==== dv/xap_unit_tb.sv ====
// Self-checking bench for the pointer unit.
// Assumes a zero-wait slave and the memory model on the address port.
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; $display("Error %0t: %h vs %h", $time, a, b); end end
module xap_unit_tb;
    import xap_pkg::*;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, pm = 0, im = 0, st = 0, hready, hresp, xv;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rdat;
    logic [7:0] wreg = 0, p2 = 0;
    logic [23:0] xa, seen;
    logic [7:0] ix [10] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h93, 8'h95, 8'h9D, 8'hDA, 8'hEA};
    logic [7:0] v [10] = '{8'h56, 8'h34, 8'hBC, 8'h9A, 8'h00, 8'h12, 8'h78, 8'h00, 8'h33, 8'hEE};
    int fails = 0, cmp_count = 0, cyc = 0;
    // 20 MHz clock
    always #25 hclk = ~hclk;
    xap_unit dut(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
        .cpu_ptr_move(pm), .cpu_ind_move(im), .cpu_work_reg(wreg), .port_two_latch(p2), .cpu_ptr_step(st),
        .xram_addr(xa), .xram_addr_valid(xv));
    xap_xram_model xm(.hclk(hclk), .xram_addr(xa), .xram_addr_valid(xv), .seen_addr(seen));
    // One single word transfer
    task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1;
        haddr <= {22'h0, i, 2'h0};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rdat = hrdata;
    endtask : bus
    task automatic rc(input logic [7:0] i, input logic [7:0] e);
        bus(0, i, 8'h00);
        `CHK(rdat, {24'h0, e})
    endtask : rc
    // Move request, then strobe and latched address
    task automatic mv(input logic ind, input logic [23:0] e);
        @(posedge hclk);
        pm <= !ind;
        im <= ind;
        @(posedge hclk);
        pm <= 0;
        im <= 0;
        @(negedge hclk);
        `CHK(xv, 1'b1)
        @(negedge hclk);
        `CHK(seen, e)
    endtask : mv
    task automatic step;
        @(posedge hclk);
        st <= 1;
        @(posedge hclk);
        st <= 0;
    endtask : step
    task automatic t_regs;
        foreach (ix[k]) begin
            rc(ix[k], 8'h00);
            bus(1, ix[k], 8'hFF);
            rc(ix[k], ix[k] == 8'h86 ? PSC_WR_MASK : ix[k] == 8'h9D ? AMC_WR_MASK : 8'hFF);
            bus(1, ix[k], 8'h00);
        end
        bus(1, 8'hC0, 8'h5A);
        rc(8'hC0, 8'h00);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_move;
        foreach (ix[k]) bus(1, ix[k], v[k]);
        mv(0, 24'h123456);
        bus(1, 8'h86, 8'h01);
        mv(0, 24'h789ABC);
        wreg <= 8'h11;
        p2 <= 8'h22;
        mv(1, 24'hEE2211);
        bus(1, 8'h9D, 8'h08);
        mv(1, 24'hEE3311);
        $display("t_move done");
    endtask : t_move
    task automatic t_step;
        for (int c = 0; c < 4; c++) begin
            for (int s = 0; s < 2; s++) begin
                bus(1, 8'h86, {c[1:0], 5'h0, s[0]});
                bus(1, 8'h82 + 8'(2 * s), 8'h80);
                step();
                rc(8'h82 + 8'(2 * s), (s ? c[1] : c[0]) ? 8'h7F : 8'h81);
            end
        end
        bus(1, 8'h86, 8'h00);
        bus(1, 8'h9D, 8'h02);
        bus(1, 8'h82, 8'hFF);
        bus(1, 8'h83, 8'hFF);
        step();
        rc(8'h93, 8'h13);
        bus(1, 8'h9D, 8'h00);
        bus(1, 8'h82, 8'hFF);
        bus(1, 8'h83, 8'hFF);
        step();
        rc(8'h93, 8'h13);
        rc(8'h83, 8'h00);
        $display("t_step done");
    endtask : t_step
    task automatic t_tog;
        bus(1, 8'h86, 8'h20);
        mv(0, 24'h130000);
        rc(8'h86, 8'h21);
        step();
        rc(8'h86, 8'h20);
        $display("t_tog done");
    endtask : t_tog
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1;
        t_regs();
        t_move();
        t_step();
        t_tog();
        give_verdict();
    end
    // Hang guard, far above the expected run
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            give_verdict();
        end
    end
endmodule : xap_unit_tb
